// ---- core/ptm_timer.sv ----
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ptm_timer
   import ptm_pkg::*;
#(
   parameter int unsigned CNT_W = 16,
   parameter bit IS_ZERO = 1'b1
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic hi_clk_tick,
   input wire logic sub_clk_tick,
   input wire logic ext_clock_pin,
   input wire logic capture_in_pin,
   output logic timer_out_pin,
   output logic timer_out_inv_pin,
   output logic match_a_event,
   output logic match_p_event
);

   localparam logic [15:0] CNT_MASK = 16'((32'h0000_0001 << CNT_W) - 32'h0000_0001);

   // Register group
   ptm_ctrl0_t ctrl0, next_ctrl0;
   ptm_ctrl1_t ctrl1, next_ctrl1;
   ptm_ctrl2_t ctrl2, next_ctrl2;
   logic [15:0] cmp_a, next_cmp_a;
   logic [15:0] cmp_b, next_cmp_b;
   logic [15:0] period, next_period;
   logic [7:0] lo_buf, next_lo_buf;
   logic aw_got, next_aw_got;
   logic [7:0] aw_addr, next_aw_addr;
   logic w_got, next_w_got;
   logic [7:0] w_data, next_w_data;
   logic w_lane0, next_w_lane0;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic [7:0] rd_addr, next_rd_addr;
   logic wr_fire;
   logic rd_fire;

   // Counter group
   logic [15:0] cnt, next_cnt;
   logic run_q, next_run_q;
   logic out_lvl, next_out_lvl;
   logic pulse_on, next_pulse_on;
   logic cap_q, next_cap_q;
   logic next_pin;
   logic next_match_a;
   logic next_match_p;

   logic tick;
   logic ext_rise;
   logic run_rise;
   logic at_top;
   logic hit_a;
   logic hit_p;
   logic clr;
   logic cap_src;
   logic cap_rise;
   logic cap_fall;
   logic cap_evt;
   logic to_b;
   logic cap_a;
   logic cap_b;
   logic active;

   // Pause gates only the count enable; dividers and bus stay alive
   ptm_tick_gen u_tick (
      .clk(clk),
      .rst_b(rst_b),
      .enable(ctrl0.timer_run && run_q && !ctrl0.count_hold),
      .clk_sel(ctrl0.count_clock_sel),
      .hi_clk_tick(hi_clk_tick),
      .sub_clk_tick(sub_clk_tick),
      .ext_clock_pin(ext_clock_pin),
      .tick(tick),
      .ext_rise(ext_rise)
   );

   assign awready = !aw_got;
   assign wready = !w_got;
   assign arready = !rvalid;
   assign wr_fire = aw_got && w_got && !bvalid;
   assign rd_fire = arvalid && !rvalid;

   always_comb begin
      next_ctrl0 = ctrl0;
      next_ctrl1 = ctrl1;
      next_ctrl2 = ctrl2;
      next_cmp_a = cmp_a;
      next_cmp_b = cmp_b;
      next_period = period;
      next_lo_buf = lo_buf;
      next_aw_got = aw_got;
      next_aw_addr = aw_addr;
      next_w_got = w_got;
      next_w_data = w_data;
      next_w_lane0 = w_lane0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      next_rd_addr = rd_addr;
      if (awvalid && !aw_got) begin
         next_aw_got = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && !w_got) begin
         next_w_got = 1'b1;
         next_w_data = wdata[7:0];
         next_w_lane0 = wstrb[0];
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         case (aw_addr)
            OFF_CTRL0: if (w_lane0) next_ctrl0 = w_data & CTRL0_WR_MASK;
            OFF_CTRL1: if (w_lane0) next_ctrl1 = w_data;
            OFF_CTRL2: begin
               if (!IS_ZERO) next_bresp = RESP_SLVERR;
               else if (w_lane0) next_ctrl2 = w_data & CTRL2_WR_MASK;
            end
            OFF_CNT_LO, OFF_CNT_HI: next_bresp = RESP_OKAY;
            OFF_CMPA_LO, OFF_PER_LO: if (w_lane0) next_lo_buf = w_data;
            OFF_CMPB_LO: begin
               if (!IS_ZERO) next_bresp = RESP_SLVERR;
               else if (w_lane0) next_lo_buf = w_data;
            end
            OFF_CMPA_HI: if (w_lane0) next_cmp_a = {w_data, lo_buf} & CNT_MASK;
            OFF_PER_HI: if (w_lane0) next_period = {w_data, lo_buf} & CNT_MASK;
            OFF_CMPB_HI: begin
               if (!IS_ZERO) next_bresp = RESP_SLVERR;
               else if (w_lane0) next_cmp_b = {w_data, lo_buf} & CNT_MASK;
            end
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (rd_fire) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = 32'h0000_0000;
         next_rd_addr = araddr;
         case (araddr)
            OFF_CTRL0: next_rdata[7:0] = ctrl0 & CTRL0_WR_MASK;
            OFF_CTRL1: next_rdata[7:0] = ctrl1;
            OFF_CTRL2: begin
               if (IS_ZERO) next_rdata[7:0] = ctrl2;
               else next_rresp = RESP_SLVERR;
            end
            OFF_CNT_LO, OFF_CMPA_LO, OFF_PER_LO: next_rdata[7:0] = lo_buf;
            OFF_CMPB_LO: begin
               if (IS_ZERO) next_rdata[7:0] = lo_buf;
               else next_rresp = RESP_SLVERR;
            end
            OFF_CNT_HI: begin
               next_rdata[7:0] = cnt[15:8] & CNT_MASK[15:8];
               next_lo_buf = cnt[7:0];
            end
            OFF_CMPA_HI: begin
               next_rdata[7:0] = cmp_a[15:8];
               next_lo_buf = cmp_a[7:0];
            end
            OFF_PER_HI: begin
               next_rdata[7:0] = period[15:8];
               next_lo_buf = period[7:0];
            end
            OFF_CMPB_HI: begin
               if (IS_ZERO) begin
                  next_rdata[7:0] = cmp_b[15:8];
                  next_lo_buf = cmp_b[7:0];
               end else begin
                  next_rresp = RESP_SLVERR;
               end
            end
            default: next_rresp = RESP_SLVERR;
         endcase
      end
      // Capture overrides a bus write landing in the same cycle
      if (cap_a) next_cmp_a = cnt;
      if (cap_b) next_cmp_b = cnt;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl0 <= CTRL_RST;
         ctrl1 <= CTRL_RST;
         ctrl2 <= CTRL_RST;
         cmp_a <= 16'h0000;
         cmp_b <= 16'h0000;
         period <= 16'h0000;
         lo_buf <= 8'h00;
         aw_got <= 1'b0;
         aw_addr <= 8'h00;
         w_got <= 1'b0;
         w_data <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
         rd_addr <= 8'h00;
      end else begin
         ctrl0 <= next_ctrl0;
         ctrl1 <= next_ctrl1;
         ctrl2 <= next_ctrl2;
         cmp_a <= next_cmp_a;
         cmp_b <= next_cmp_b;
         period <= next_period;
         lo_buf <= next_lo_buf;
         aw_got <= next_aw_got;
         aw_addr <= next_aw_addr;
         w_got <= next_w_got;
         w_data <= next_w_data;
         w_lane0 <= next_w_lane0;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         rd_addr <= next_rd_addr;
      end
   end

   always_comb begin
      run_rise = ctrl0.timer_run && !run_q;
      at_top = (period == 16'h0000) ? (cnt == CNT_MASK) : (cnt == period);
      hit_a = tick && (cnt == cmp_a);
      hit_p = tick && at_top;
      if ((ctrl1.op_mode_sel == PTM_MODE_CMP || ctrl1.op_mode_sel == PTM_MODE_TMR)
          && ctrl1.clear_source_sel) begin
         clr = hit_a;
      end else begin
         clr = hit_p;
      end
      next_run_q = ctrl0.timer_run;
      next_cnt = cnt;
      if (run_rise) begin
         next_cnt = 16'h0000;
      end else if (tick) begin
         next_cnt = clr ? 16'h0000 : (16'(cnt + 16'h0001) & CNT_MASK);
      end
      next_match_a = hit_a;
      next_match_p = hit_p;
      cap_src = ctrl1.capture_src_sel ? ext_clock_pin : capture_in_pin;
      next_cap_q = cap_src;
      cap_rise = cap_src && !cap_q;
      cap_fall = !cap_src && cap_q;
      cap_evt = (ctrl1.op_mode_sel == PTM_MODE_CAP) && ctrl0.timer_run
                && (((ctrl1.pin_action_sel == CAP_RISE) && cap_rise)
                    || ((ctrl1.pin_action_sel == CAP_FALL) && cap_fall)
                    || ((ctrl1.pin_action_sel == CAP_BOTH) && (cap_rise || cap_fall)));
      to_b = IS_ZERO && (ctrl2.capture_route_hi || ctrl2.capture_route_lo) && cap_rise;
      cap_a = cap_evt && !to_b;
      cap_b = cap_evt && to_b;
      next_pulse_on = pulse_on;
      if (run_rise) next_pulse_on = 1'b0;
      else if (hit_a) next_pulse_on = 1'b0;
      if (ext_rise && ctrl0.timer_run) next_pulse_on = 1'b1;
      case (ctrl1.pin_action_sel)
         ACT_INACTIVE: active = 1'b0;
         ACT_ACTIVE: active = 1'b1;
         ACT_PWM: active = (cnt < cmp_a);
         ACT_PULSE: active = pulse_on;
         default: active = 1'b0;
      endcase
      next_out_lvl = out_lvl;
      case (ctrl1.op_mode_sel)
         PTM_MODE_CMP: begin
            if (run_rise) begin
               next_out_lvl = ctrl1.out_initial_level;
            end else if (hit_a) begin
               case (ctrl1.pin_action_sel)
                  ACT_LOW: next_out_lvl = 1'b0;
                  ACT_HIGH: next_out_lvl = 1'b1;
                  ACT_TOGGLE: next_out_lvl = !out_lvl;
                  default: next_out_lvl = out_lvl;
               endcase
            end
         end
         PTM_MODE_PWM: begin
            if (run_rise) next_out_lvl = ctrl1.out_initial_level;
            else next_out_lvl = active ? ctrl1.out_initial_level : !ctrl1.out_initial_level;
         end
         PTM_MODE_CAP: next_out_lvl = out_lvl;
         PTM_MODE_TMR: next_out_lvl = 1'b0;
         default: next_out_lvl = out_lvl;
      endcase
      if (ctrl1.op_mode_sel == PTM_MODE_TMR) begin
         next_pin = 1'b0;
      end else begin
         next_pin = next_out_lvl ^ ctrl1.out_invert;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt <= 16'h0000;
         run_q <= 1'b0;
         out_lvl <= 1'b0;
         pulse_on <= 1'b0;
         cap_q <= 1'b0;
         timer_out_pin <= 1'b0;
         timer_out_inv_pin <= 1'b1;
         match_a_event <= 1'b0;
         match_p_event <= 1'b0;
      end else begin
         cnt <= next_cnt;
         run_q <= next_run_q;
         out_lvl <= next_out_lvl;
         pulse_on <= next_pulse_on;
         cap_q <= next_cap_q;
         timer_out_pin <= next_pin;
         timer_out_inv_pin <= !next_pin;
         match_a_event <= next_match_a;
         match_p_event <= next_match_p;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_run_rise;
      ctrl0.timer_run && !run_q;
   endsequence

   sequence s_a_hi_write;
      wr_fire && (aw_addr == OFF_CMPA_HI) && w_lane0 && !cap_a;
   endsequence

   property p_run_clear;
      s_run_rise |=> (cnt == 16'h0000) ##1 (cnt <= 16'h0001);
   endproperty
   a_run_clear: assert property (p_run_clear) else $error("Run rise did not clear");

   property p_hold;
      (ctrl0.timer_run && run_q && ctrl0.count_hold) |=> $stable(cnt);
   endproperty
   a_hold: assert property (p_hold) else $error("Counter moved while held");

   property p_off;
      (!ctrl0.timer_run && !run_q) |=> $stable(cnt);
   endproperty
   a_off: assert property (p_off) else $error("Counter moved while off");

   property p_ovf;
      (tick && cnt == CNT_MASK) |=> (cnt == 16'h0000)
         && match_p_event == $past((period == 16'h0000) || (period == CNT_MASK));
   endproperty
   a_ovf: assert property (p_ovf) else $error("Overflow did not wrap");

   property p_clear_a;
      (hit_a && !run_rise && ctrl1.clear_source_sel && ctrl1.op_mode_sel == PTM_MODE_CMP)
         |=> (cnt == 16'h0000) && match_a_event;
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("Match A did not clear");

   property p_ctrl0_rsv;
      (rvalid && rd_addr == OFF_CTRL0) |-> (rdata[2:0] == 3'h0) && (rdata[31:8] == 24'h00_0000);
   endproperty
   a_ctrl0_rsv: assert property (p_ctrl0_rsv) else $error("Reserved bits nonzero");

   property p_inv_pin;
      timer_out_inv_pin == !timer_out_pin;
   endproperty
   a_inv_pin: assert property (p_inv_pin) else $error("Complement pin wrong");

   property p_toggle;
      (ctrl1.op_mode_sel == PTM_MODE_CMP && ctrl1.pin_action_sel == ACT_TOGGLE && hit_a
       && !run_rise && $stable(ctrl1)) |=> timer_out_pin != $past(timer_out_pin);
   endproperty
   a_toggle: assert property (p_toggle) else $error("Toggle did not flip pin");

   property p_a_hi_write;
      s_a_hi_write |=> cmp_a == ($past({w_data, lo_buf}) & CNT_MASK);
   endproperty
   a_a_hi_write: assert property (p_a_hi_write) else $error("High write bad latch");

   property p_bresp;
      wr_fire |=> bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("Write response missing");

   property p_bhold;
      (bvalid && !bready) |=> bvalid && $stable(bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("Write response dropped");

   property p_narrow_hi;
      (rvalid && rd_addr == OFF_CNT_HI) |-> (rdata[7:0] & ~CNT_MASK[15:8]) == 8'h00;
   endproperty
   a_narrow_hi: assert property (p_narrow_hi) else $error("Unused high bits set");

endmodule

// ---- core/ptm_pkg.sv ----
package ptm_pkg;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFF_CTRL0 = 8'h00;
   localparam logic [7:0] OFF_CTRL1 = 8'h04;
   localparam logic [7:0] OFF_CTRL2 = 8'h08;
   localparam logic [7:0] OFF_CNT_LO = 8'h0c;
   localparam logic [7:0] OFF_CNT_HI = 8'h10;
   localparam logic [7:0] OFF_CMPA_LO = 8'h14;
   localparam logic [7:0] OFF_CMPA_HI = 8'h18;
   localparam logic [7:0] OFF_CMPB_LO = 8'h1c;
   localparam logic [7:0] OFF_CMPB_HI = 8'h20;
   localparam logic [7:0] OFF_PER_LO = 8'h24;
   localparam logic [7:0] OFF_PER_HI = 8'h28;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL0_WR_MASK = 8'hf8;
   localparam logic [7:0] CTRL2_WR_MASK = 8'h07;

   // Counter clock selections
   localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
   localparam logic [2:0] CKS_SYS = 3'h1;
   localparam logic [2:0] CKS_HI_DIV16 = 3'h2;
   localparam logic [2:0] CKS_HI_DIV64 = 3'h3;
   localparam logic [2:0] CKS_SUB_A = 3'h4;
   localparam logic [2:0] CKS_SUB_B = 3'h5;
   localparam logic [2:0] CKS_EXT_RISE = 3'h6;
   localparam logic [2:0] CKS_EXT_FALL = 3'h7;

   // Divider terminal counts
   localparam logic [5:0] DIV4_LAST = 6'h03;
   localparam logic [3:0] DIV16_LAST = 4'hf;
   localparam logic [5:0] DIV64_LAST = 6'h3f;

   // Pin actions, compare mode
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   // Pin actions, PWM / single-pulse mode
   localparam logic [1:0] ACT_INACTIVE = 2'h0;
   localparam logic [1:0] ACT_ACTIVE = 2'h1;
   localparam logic [1:0] ACT_PWM = 2'h2;
   localparam logic [1:0] ACT_PULSE = 2'h3;
   // Capture edges
   localparam logic [1:0] CAP_RISE = 2'h0;
   localparam logic [1:0] CAP_FALL = 2'h1;
   localparam logic [1:0] CAP_BOTH = 2'h2;

   typedef enum logic [1:0] {
      PTM_MODE_CMP = 2'b00,
      PTM_MODE_CAP = 2'b01,
      PTM_MODE_PWM = 2'b10,
      PTM_MODE_TMR = 2'b11
   } ptm_mode_t;

   typedef struct packed {
      logic count_hold;
      logic [2:0] count_clock_sel;
      logic timer_run;
      logic [2:0] rsv;
   } ptm_ctrl0_t;

   typedef struct packed {
      ptm_mode_t op_mode_sel;
      logic [1:0] pin_action_sel;
      logic out_initial_level;
      logic out_invert;
      logic capture_src_sel;
      logic clear_source_sel;
   } ptm_ctrl1_t;

   typedef struct packed {
      logic [4:0] rsv;
      logic capture_route_hi;
      logic capture_route_lo;
      logic capture_extra_flag;
   } ptm_ctrl2_t;

endpackage

// ---- core/ptm_tick_gen.sv ----
`timescale 1ns/1ps
module ptm_tick_gen
   import ptm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic [2:0] clk_sel,
   input wire logic hi_clk_tick,
   input wire logic sub_clk_tick,
   input wire logic ext_clock_pin,
   output logic tick,
   output logic ext_rise
);

   logic [5:0] sys_div;
   logic [5:0] hi_div;
   logic ext_q;
   logic [5:0] next_sys_div;
   logic [5:0] next_hi_div;
   logic next_ext_q;
   logic src;
   logic ext_fall;

   always_comb begin
      next_sys_div = (sys_div == DIV4_LAST) ? 6'h00 : 6'(sys_div + 6'h01);
      next_hi_div = hi_clk_tick ? 6'(hi_div + 6'h01) : hi_div;
      next_ext_q = ext_clock_pin;
      ext_rise = ext_clock_pin && !ext_q;
      ext_fall = !ext_clock_pin && ext_q;
      case (clk_sel)
         CKS_SYS_DIV4: src = (sys_div == DIV4_LAST);
         CKS_SYS: src = 1'b1;
         CKS_HI_DIV16: src = hi_clk_tick && (hi_div[3:0] == DIV16_LAST);
         CKS_HI_DIV64: src = hi_clk_tick && (hi_div == DIV64_LAST);
         CKS_SUB_A: src = sub_clk_tick;
         CKS_SUB_B: src = sub_clk_tick;
         CKS_EXT_RISE: src = ext_rise;
         CKS_EXT_FALL: src = ext_fall;
         default: src = 1'b0;
      endcase
      tick = enable && src;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sys_div <= 6'h00;
         hi_div <= 6'h00;
         ext_q <= 1'b0;
      end else begin
         sys_div <= next_sys_div;
         hi_div <= next_hi_div;
         ext_q <= next_ext_q;
      end
   end

endmodule

// ---- tb/ptm_pin_model.sv ----
`timescale 1ns/1ps
module ptm_pin_model (
   input wire logic clk,
   input wire logic rst_b,
   output logic hi_clk_tick,
   output logic sub_clk_tick,
   output logic ext_clock_pin,
   output logic capture_in_pin
);
   logic [3:0] phase;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         phase <= 4'h0;
      end else begin
         phase <= phase + 4'h1;
      end
   end
   // High clock every 2 cycles, sub clock every 16, ext clock pin edges every 4, capture pin edges every 8
   assign hi_clk_tick = phase[0];
   assign sub_clk_tick = (phase == 4'hf);
   assign ext_clock_pin = phase[2];
   assign capture_in_pin = phase[3];
endmodule

// ---- tb/ptm_timer_tb.sv ----
`timescale 1ns/1ps
module ptm_timer_tb
   import ptm_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, hi_clk_tick, sub_clk_tick;
   logic ext_clock_pin, capture_in_pin, timer_out_pin, timer_out_inv_pin;
   logic match_a_event, match_p_event;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   int mismatches = 0, num_checks = 0, cycles = 0;

   always #5 clk = ~clk;

   ptm_timer #(.CNT_W(16), .IS_ZERO(1'b1)) u_ptm_timer (.clk, .rst_b, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .rvalid, .rready, .rdata, .rresp, .hi_clk_tick, .sub_clk_tick, .ext_clock_pin,
      .capture_in_pin, .timer_out_pin, .timer_out_inv_pin, .match_a_event, .match_p_event);

   ptm_pin_model u_ptm_pin_model (.clk, .rst_b, .hi_clk_tick, .sub_clk_tick, .ext_clock_pin,
      .capture_in_pin);

   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         mismatches++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb) begin
         @(negedge clk);
         ta = awvalid && (awready === 1'b1);
         tw = wvalid && (wready === 1'b1);
         tb = (bvalid === 1'b1);
         resp = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a);
      logic ta, tr;
      tr = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr) begin
         @(negedge clk);
         ta = arvalid && (arready === 1'b1);
         tr = (rvalid === 1'b1);
         rd = rdata;
         resp = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   task automatic evt_gap(input bit use_a, output int n);
      @(negedge clk);
      while ((use_a ? match_a_event : match_p_event) !== 1'b1) @(negedge clk);
      @(negedge clk);
      n = 1;
      while ((use_a ? match_a_event : match_p_event) !== 1'b1) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic t_regs();
      rdr(OFF_CTRL0);
      chk_v(rd, {24'h00_0000, CTRL_RST});
      rdr(OFF_CTRL1);
      chk_v(rd, 32'h0000_0000);
      wr(OFF_CTRL0, 8'hf7);
      rdr(OFF_CTRL0);
      chk_v(rd, 32'h0000_00f0);
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_PER_LO, 8'h34);
      rdr(OFF_PER_HI);
      rdr(OFF_PER_LO);
      chk_v(rd, 32'h0000_0000);
      wr(OFF_PER_LO, 8'h34);
      wr(OFF_PER_HI, 8'h12);
      rdr(OFF_PER_HI);
      chk_v(rd, 32'h0000_0012);
      rdr(OFF_PER_LO);
      chk_v(rd, 32'h0000_0034);
      wr(OFF_CMPB_LO, 8'h22);
      wr(OFF_CMPB_HI, 8'h01);
      rdr(OFF_CMPB_HI);
      chk_v(rd, 32'h0000_0001);
      wr(OFF_CNT_HI, 8'h55);
      chk_v(resp, RESP_OKAY);
      rdr(OFF_CNT_HI);
      chk_v(rd, 32'h0000_0000);
      wr(8'h3c, 8'h01);
      chk_v(resp, RESP_SLVERR);
      rdr(8'h3c);
      chk_v(resp, RESP_SLVERR);
      $display("test registers done");
   endtask

   task automatic t_clk();
      logic [7:0] sel [6] = '{8'h18, 8'h08, 8'h28, 8'h48, 8'h68, 8'h78};
      int exp [6] = '{4, 16, 128, 64, 32, 32};
      int n;
      wr(OFF_PER_LO, 8'h03);
      wr(OFF_PER_HI, 8'h00);
      wr(OFF_CTRL1, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(OFF_CTRL0, 8'h00);
         wr(OFF_CTRL0, sel[i]);
         evt_gap(1'b0, n);
         chk_n(n, exp[i]);
      end
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_CMPA_LO, 8'h06);
      wr(OFF_CMPA_HI, 8'h00);
      wr(OFF_CTRL1, 8'h01);
      wr(OFF_CTRL0, 8'h18);
      evt_gap(1'b1, n);
      chk_n(n, 7);
      $display("test clock sources done");
   endtask

   task automatic t_hold();
      logic [31:0] v;
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_CTRL1, 8'h00);
      wr(OFF_PER_HI, 8'h10);
      wr(OFF_CTRL0, 8'h18);
      repeat (20) @(posedge clk);
      wr(OFF_CTRL0, 8'h98);
      rdr(OFF_CNT_HI);
      rdr(OFF_CNT_LO);
      v = rd;
      repeat (10) @(posedge clk);
      rdr(OFF_CNT_HI);
      rdr(OFF_CNT_LO);
      chk_v(rd, v);
      wr(OFF_CTRL0, 8'h18);
      wr(OFF_CTRL0, 8'h10);
      rdr(OFF_CNT_HI);
      rdr(OFF_CNT_LO);
      chk_n(int'(rd > v && rd < v + 32'd20), 1);
      $display("test hold done");
   endtask

   task automatic t_out();
      wr(OFF_PER_LO, 8'h40);
      wr(OFF_PER_HI, 8'h00);
      wr(OFF_CMPA_LO, 8'h08);
      wr(OFF_CMPA_HI, 8'h00);
      wr(OFF_CTRL1, 8'h20);
      wr(OFF_CTRL0, 8'h18);
      repeat (2) @(negedge clk);
      chk_v(timer_out_pin, 1'b0);
      while (match_a_event !== 1'b1) @(negedge clk);
      repeat (2) @(negedge clk);
      chk_v(timer_out_pin, 1'b1);
      chk_v(timer_out_inv_pin, 1'b0);
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_CTRL1, 8'h24);
      wr(OFF_CTRL0, 8'h18);
      repeat (2) @(negedge clk);
      chk_v(timer_out_pin, 1'b1);
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_CTRL1, 8'h98);
      wr(OFF_CTRL0, 8'h18);
      repeat (3) @(negedge clk);
      chk_v(timer_out_pin, 1'b1);
      chk_v(timer_out_inv_pin, 1'b0);
      $display("test output pin done");
   endtask

   task automatic t_modes();
      int n;
      logic [31:0] v;
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_CTRL1, 8'h30);
      wr(OFF_CTRL0, 8'h18);
      @(negedge clk);
      while (match_a_event !== 1'b1) @(negedge clk);
      chk_v(timer_out_pin, 1'b1);
      @(negedge clk);
      while (match_a_event !== 1'b1) @(negedge clk);
      chk_v(timer_out_pin, 1'b0);
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_CTRL1, 8'ha8);
      wr(OFF_CTRL0, 8'h18);
      @(negedge clk);
      while (match_p_event !== 1'b1) @(negedge clk);
      n = 0;
      repeat (65) begin
         @(negedge clk);
         if (timer_out_pin === 1'b1) n++;
      end
      chk_n(n, 8);
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_CTRL1, 8'hc5);
      wr(OFF_CTRL0, 8'h18);
      evt_gap(1'b1, n);
      chk_n(n, 9);
      chk_v(timer_out_pin, 1'b0);
      chk_v(timer_out_inv_pin, 1'b1);
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_CTRL1, 8'h40);
      wr(OFF_CTRL0, 8'h18);
      wr(OFF_CTRL0, 8'h98);
      rdr(OFF_CNT_HI);
      rdr(OFF_CNT_LO);
      v = rd;
      repeat (20) @(posedge clk);
      rdr(OFF_CMPA_HI);
      rdr(OFF_CMPA_LO);
      chk_v(rd, v);
      $display("test modes done");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_clk();
      t_hold();
      t_out();
      t_modes();
      finish_test();
   end
endmodule
